// ===== design/srcc_top.sv
// Standby, reset scope and system clock control
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module srcc_top
    import srcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // External pins
    input wire logic reset_pin_n,
    input wire logic low_tick_pin,
    // CPU side
    input wire logic break_instruction,
    input wire logic [SRCC_NIRQ-1:0] irq_enable,
    input wire logic [SRCC_NIRQ-1:0] irq_request,
    output logic cpu_clk_en,
    output logic cpu_reset,
    output logic pll_run,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    // Peripheral blocks
    output logic [SRCC_NPER-1:0] periph_rst,
    output logic [SRCC_NPER-1:0] periph_clk_en
);
    // Synchronisers and edges
    logic [1:0] pin_sync;
    logic [2:0] tick_sync;
    logic pin_rst;
    logic low_tick;
    logic sfr_rst;
    // Registers and state
    srcc_state_t state, next_state;
    logic [3:0] div_cnt, next_div_cnt;
    logic [3:0] brk_cnt, next_brk_cnt;
    logic halt_request_bit, next_halt_request_bit;
    logic stop_request_bit, next_stop_request_bit;
    logic master_irq_enable, next_master_irq_enable;
    logic clk_low_sel, next_clk_low_sel;
    logic stop_code_gate, next_stop_code_gate;
    logic key_half, next_key_half;
    logic [7:0] peripheral_block_ctrl, next_peripheral_block_ctrl;
    logic [3:0] irq_stat, next_irq_stat;
    logic [3:0] irq_mask, next_irq_mask;
    logic [7:0] next_rdata;
    logic next_cpu_clk_en, next_cpu_reset, next_pll_run, next_irq;
    logic low_osc_seen, next_low_osc_seen;
    // Decodes
    logic pend, wake, div_tick, periph_tick;
    logic [3:0] events;

    assign pin_rst = !pin_sync[1];
    assign sfr_rst = rst || pin_rst;
    assign low_tick = tick_sync[1] && !tick_sync[2];
    assign pend = |(irq_enable & irq_request);
    assign wake = pend;
    assign div_tick = (div_cnt == SRCC_DIV_LAST);
    assign periph_tick = (state != SRCC_STOP) && div_tick;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_sync <= 2'h0;
            tick_sync <= 3'h0;
        end
        else
        begin
            pin_sync <= {pin_sync[0], reset_pin_n};
            tick_sync <= {tick_sync[1:0], low_tick_pin};
        end
    end

    // Power state, divider and break reset stretch
    always_comb
    begin
        next_state = state;
        next_div_cnt = div_cnt + 4'h1;
        next_brk_cnt = (brk_cnt != 4'h0) ? brk_cnt - 4'h1 : 4'h0;
        if (break_instruction)
            next_brk_cnt = SRCC_BRK_CYC;
        unique case (state)
            SRCC_RUN:
            begin
                // Takes effect at once; the trailing no-operations cover the pipeline
                if (stop_request_bit)
                    next_state = SRCC_STOP;
                else if (halt_request_bit)
                    next_state = SRCC_HALT;
            end
            SRCC_HALT:
            begin
                if (wake)
                    next_state = SRCC_RUN;
            end
            SRCC_STOP:
            begin
                if (wake)
                    next_state = SRCC_RUN;
            end
            default:
                next_state = SRCC_RUN;
        endcase
        if (state == SRCC_STOP)
            next_div_cnt = 4'h0;
        // CPU clock: PLL/16 by default, low tick when selected
        next_cpu_clk_en = (state == SRCC_RUN)
            && (clk_low_sel ? low_tick : div_tick);
        next_pll_run = (next_state != SRCC_STOP);
        // Pin or break reset reaches the CPU; RAM has no clear path at all
        next_cpu_reset = pin_rst || (next_brk_cnt != 4'h0);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sfr_rst)
        begin
            state <= SRCC_RUN;
            div_cnt <= 4'h0;
            brk_cnt <= 4'h0;
            cpu_clk_en <= 1'b0;
            cpu_reset <= 1'b1;
            pll_run <= 1'b1;
        end
        else
        begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            brk_cnt <= next_brk_cnt;
            cpu_clk_en <= next_cpu_clk_en;
            cpu_reset <= next_cpu_reset;
            pll_run <= next_pll_run;
        end
    end

    // Register file; only pin or power-on reset initialises it
    always_comb
    begin
        next_halt_request_bit = halt_request_bit;
        next_stop_request_bit = stop_request_bit;
        next_master_irq_enable = master_irq_enable;
        next_clk_low_sel = clk_low_sel;
        next_stop_code_gate = stop_code_gate;
        next_key_half = key_half;
        next_peripheral_block_ctrl = peripheral_block_ctrl;
        next_irq_mask = irq_mask;
        next_low_osc_seen = low_osc_seen || low_tick;
        next_rdata = 8'h00;
        events = 4'h0;
        events[SRCC_EV_TICK] = low_tick;
        events[SRCC_EV_WAKE] = (state != SRCC_RUN) && wake;
        events[SRCC_EV_BRK] = break_instruction;
        if (wr)
        begin
            unique case (addr)
                SRCC_CTRL_OFS:
                begin
                    next_halt_request_bit = wdata[SRCC_CTRL_HALT];
                    next_master_irq_enable = wdata[SRCC_CTRL_MIE];
                    next_clk_low_sel = wdata[SRCC_CTRL_LOWSEL];
                    if (wdata[SRCC_CTRL_STOP] && !stop_code_gate)
                        events[SRCC_EV_REFUSE] = 1'b1;
                    else
                        next_stop_request_bit = wdata[SRCC_CTRL_STOP];
                end
                SRCC_GATE_OFS:
                begin
                    next_key_half = (wdata == SRCC_KEY1);
                    if (key_half && wdata == SRCC_KEY2)
                    begin
                        if (!master_irq_enable && pend)
                            events[SRCC_EV_REFUSE] = 1'b1;
                        else
                            next_stop_code_gate = 1'b1;
                    end
                end
                SRCC_BLK_OFS: next_peripheral_block_ctrl = wdata;
                SRCC_IRQM_OFS: next_irq_mask = wdata[3:0];
                default: ;
            endcase
        end
        // Request bits consumed on entering standby; the gate only on entering stop
        if (state == SRCC_RUN && stop_request_bit)
        begin
            next_stop_request_bit = 1'b0;
            next_stop_code_gate = 1'b0;
        end
        if (state == SRCC_RUN && halt_request_bit)
            next_halt_request_bit = 1'b0;
        // Read clears status; a new event in that cycle wins
        next_irq_stat = ((rd && addr == SRCC_IRQS_OFS) ? 4'h0 : irq_stat) | events;
        if (rd)
        begin
            unique case (addr)
                SRCC_CTRL_OFS: next_rdata = {4'h0, clk_low_sel, master_irq_enable,
                    stop_request_bit, halt_request_bit};
                SRCC_GATE_OFS: next_rdata = {7'h00, stop_code_gate};
                SRCC_BLK_OFS: next_rdata = peripheral_block_ctrl;
                // No bit here or anywhere tells a pin reset apart
                SRCC_STAT_OFS: next_rdata = {4'h0, low_osc_seen, stop_code_gate,
                    state};
                SRCC_IRQS_OFS: next_rdata = {4'h0, irq_stat};
                SRCC_IRQM_OFS: next_rdata = {4'h0, irq_mask};
                default: next_rdata = 8'h00;
            endcase
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // Break reset does not reach these flops
    always_ff @(posedge ref_clk)
    begin
        if (sfr_rst)
        begin
            halt_request_bit <= SRCC_CTRL_RST[SRCC_CTRL_HALT];
            stop_request_bit <= SRCC_CTRL_RST[SRCC_CTRL_STOP];
            master_irq_enable <= SRCC_CTRL_RST[SRCC_CTRL_MIE];
            clk_low_sel <= SRCC_CTRL_RST[SRCC_CTRL_LOWSEL];
            stop_code_gate <= 1'b0;
            key_half <= 1'b0;
            peripheral_block_ctrl <= SRCC_BLK_RST;
            irq_stat <= 4'h0;
            irq_mask <= SRCC_IRQM_RST;
            low_osc_seen <= 1'b0;
            rdata <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            halt_request_bit <= next_halt_request_bit;
            stop_request_bit <= next_stop_request_bit;
            master_irq_enable <= next_master_irq_enable;
            clk_low_sel <= next_clk_low_sel;
            stop_code_gate <= next_stop_code_gate;
            key_half <= next_key_half;
            peripheral_block_ctrl <= next_peripheral_block_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            low_osc_seen <= next_low_osc_seen;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    // Per-peripheral reset and clock gates
    genvar gi;
    generate
        for (gi = 0; gi < SRCC_NPER; gi++)
        begin : g_blk
            srcc_blk_gate u_gate (
                .ref_clk(ref_clk),
                .rst(sfr_rst),
                .block_bit(peripheral_block_ctrl[gi]),
                .clk_tick(periph_tick),
                .periph_rst(periph_rst[gi]),
                .periph_clk_en(periph_clk_en[gi])
            );
        end
    endgenerate

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sfr_rst);

    div_gap_a: assert property (cpu_clk_en && !clk_low_sel |=>
        (!cpu_clk_en || clk_low_sel) [*8])
        else $error("cpu clock enable faster than divide by sixteen");
    halt_clk_a: assert property (state == SRCC_HALT |=> !cpu_clk_en && pll_run)
        else $error("halt did not stop cpu clock only");
    stop_osc_a: assert property (state == SRCC_STOP && !wake |=> !pll_run
        && !cpu_clk_en) else $error("stop left oscillator running");
    gate_refuse_a: assert property ($rose(stop_code_gate) |->
        $past(master_irq_enable) || !$past(pend))
        else $error("stop gate enabled with pending request");
    stop_entry_a: assert property (state == SRCC_RUN ##1 state == SRCC_STOP |->
        $past(stop_code_gate)) else $error("stop entered without gate");
    blk_hold_a: assert property (peripheral_block_ctrl[0] |=>
        periph_rst[0] && !periph_clk_en[0]) else $error("blocked peripheral not held");
    brk_keep_a: assert property (break_instruction |=>
        $stable(peripheral_block_ctrl) && $stable(irq_mask) && cpu_reset)
        else $error("break reset disturbed registers");
    wake_run_a: assert property (state != SRCC_RUN && wake |=>
        state == SRCC_RUN ##1 pll_run) else $error("enabled request did not wake");
    irq_out_a: assert property (|(irq_stat & irq_mask) && !rd
        && !(wr && addr == SRCC_IRQM_OFS) |=> irq)
        else $error("unmasked status did not raise interrupt");

    halt_seen_c: cover property (state == SRCC_RUN ##1 state == SRCC_HALT);
    stop_seen_c: cover property (state == SRCC_STOP ##[1:50] state == SRCC_RUN);
    refuse_seen_c: cover property (next_irq_stat[SRCC_EV_REFUSE] && !master_irq_enable);
    brk_seen_c: cover property (break_instruction ##1 cpu_reset);
endmodule // srcc_top

// ===== design/srcc_pkg.sv
// Constants for the standby, reset and clock control block
package srcc_pkg;
    // Register offsets (4-bit address, 8-bit data)
    localparam logic [3:0] SRCC_CTRL_OFS = 4'h0;
    localparam logic [3:0] SRCC_GATE_OFS = 4'h1;
    localparam logic [3:0] SRCC_BLK_OFS = 4'h2;
    localparam logic [3:0] SRCC_STAT_OFS = 4'h3;
    localparam logic [3:0] SRCC_IRQS_OFS = 4'h4;
    localparam logic [3:0] SRCC_IRQM_OFS = 4'h5;
    // Control register fields
    localparam int SRCC_CTRL_HALT = 0;
    localparam int SRCC_CTRL_STOP = 1;
    localparam int SRCC_CTRL_MIE = 2;
    localparam int SRCC_CTRL_LOWSEL = 3;
    // Interrupt status fields
    localparam int SRCC_EV_TICK = 0;
    localparam int SRCC_EV_WAKE = 1;
    localparam int SRCC_EV_BRK = 2;
    localparam int SRCC_EV_REFUSE = 3;
    // Stop gate unlock keys
    localparam logic [7:0] SRCC_KEY1 = 8'h5a;
    localparam logic [7:0] SRCC_KEY2 = 8'ha5;
    // Reset values
    localparam logic [7:0] SRCC_CTRL_RST = 8'h00;
    localparam logic [7:0] SRCC_BLK_RST = 8'h00;
    localparam logic [3:0] SRCC_IRQM_RST = 4'h0;
    // PLL output divided by sixteen gives the start-up system clock
    localparam int SRCC_SYS_DIV = 16;
    localparam logic [3:0] SRCC_DIV_LAST = 4'(SRCC_SYS_DIV - 1);
    // Break reset hold time to the CPU
    localparam int SRCC_BRK_HOLD_NS = 40;
    localparam int SRCC_CLK_PERIOD_NS = 4;
    localparam logic [3:0] SRCC_BRK_CYC = 4'(SRCC_BRK_HOLD_NS / SRCC_CLK_PERIOD_NS);
    // Number of peripheral blocks and interrupt sources
    localparam int SRCC_NPER = 8;
    localparam int SRCC_NIRQ = 8;
    // Power states
    typedef enum logic [1:0] {
        SRCC_RUN = 2'b00,
        SRCC_HALT = 2'b01,
        SRCC_STOP = 2'b10
    } srcc_state_t;
endpackage

// ===== design/srcc_blk_gate.sv
// One peripheral's reset and clock gate
`timescale 1ns/1ps
module srcc_blk_gate
    import srcc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic block_bit,
    input wire logic clk_tick,
    // Peripheral side
    output logic periph_rst,
    output logic periph_clk_en
);
    logic next_periph_rst;
    logic next_periph_clk_en;

    // Block bit set: held in reset, clock stopped
    always_comb
    begin
        next_periph_rst = block_bit;
        next_periph_clk_en = clk_tick && !block_bit;
    end

    // Register outputs
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            periph_rst <= 1'b1;
            periph_clk_en <= 1'b0;
        end
        else
        begin
            periph_rst <= next_periph_rst;
            periph_clk_en <= next_periph_clk_en;
        end
    end
endmodule // srcc_blk_gate

// ===== sim/srcc_cpu_model.sv
// CPU core stand-in driving break, interrupt flags and the low tick pin
`timescale 1ns/1ps
module srcc_cpu_model
    import srcc_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // CPU side
    output logic break_instruction,
    output logic [SRCC_NIRQ-1:0] irq_enable,
    output logic [SRCC_NIRQ-1:0] irq_request,
    // Low oscillator pin
    output logic low_tick_pin
);
    // Quiet at time zero
    initial
    begin
        break_instruction = 1'b0;
        irq_enable = '0;
        irq_request = '0;
        low_tick_pin = 1'b0;
    end
    // One-cycle break request
    task automatic do_break();
        @(posedge ref_clk);
        break_instruction <= 1'b1;
        @(posedge ref_clk);
        break_instruction <= 1'b0;
    endtask
    // Raise or drop one enabled request, flag and enable together
    task automatic pend(input logic on);
        @(posedge ref_clk);
        irq_enable <= SRCC_NIRQ'({4'h0, on, 3'h0});
        irq_request <= SRCC_NIRQ'({4'h0, on, 3'h0});
    endtask
    // Low tick held long enough for the pin synchroniser
    task automatic tick();
        @(posedge ref_clk);
        low_tick_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        low_tick_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // Two idle instruction slots after a standby request
    task automatic nop2();
        repeat (2) @(posedge ref_clk);
    endtask
endmodule // srcc_cpu_model

// ===== sim/tb_standby_reset_clock_control.sv
// Self-checking bench for the standby, reset and clock control block
`timescale 1ns/1ps
module tb_standby_reset_clock_control;
    import srcc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst;
    logic reset_pin_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic break_instruction, low_tick_pin, cpu_clk_en, cpu_reset, pll_run, irq;
    logic [7:0] irq_enable, irq_request, rdata, periph_rst, periph_clk_en, v;
    int err_total = 0;
    int num_checks = 0;
    int n;
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    srcc_cpu_model cpu (.ref_clk(ref_clk), .break_instruction(break_instruction),
        .irq_enable(irq_enable), .irq_request(irq_request), .low_tick_pin(low_tick_pin));
    srcc_top dut (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
        .low_tick_pin(low_tick_pin), .break_instruction(break_instruction),
        .irq_enable(irq_enable), .irq_request(irq_request), .cpu_clk_en(cpu_clk_en),
        .cpu_reset(cpu_reset), .pll_run(pll_run), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .periph_rst(periph_rst),
        .periph_clk_en(periph_clk_en));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    // One-cycle register write
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Read strobe, data taken in the following cycle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // Cycles from one CPU clock pulse to the next, 64 if none
    task automatic gap(output int k);
        k = 0;
        while (cpu_clk_en !== 1'b1 && k < 64)
        begin
            cyc(1);
            k++;
        end
        k = 0;
        do
        begin
            cyc(1);
            k++;
        end while (cpu_clk_en !== 1'b1 && k < 64);
    endtask
    // Peripherals that saw a clock pulse in 40 cycles
    task automatic seen_clk(output logic [7:0] acc);
        acc = 8'h00;
        repeat (40)
        begin
            cyc(1);
            acc = acc | periph_clk_en;
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        // Idle bus, reset held from time zero
        rst <= 1'b1;
        reset_pin_n <= 1'b1;
        addr <= 4'h0;
        wdata <= 8'h00;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(4);
        rd_chk(SRCC_CTRL_OFS, SRCC_CTRL_RST);
        check({7'h0, pll_run}, 8'h01);
        gap(n);
        check(8'(n), 8'(SRCC_SYS_DIV));
        wr_reg(4'hf, 8'hff);
        rd_chk(4'hf, 8'h00);
        rd_chk(SRCC_BLK_OFS, SRCC_BLK_RST);
        wr_reg(SRCC_BLK_OFS, 8'ha5);
        cyc(1);
        check(periph_rst, 8'ha5);
        seen_clk(v);
        check(v, 8'h5a);
        // Break reset keeps registers
        wr_reg(SRCC_CTRL_OFS, 8'h04);
        wr_reg(SRCC_IRQM_OFS, 8'h0f);
        cpu.do_break();
        #1;
        n = 0;
        while (cpu_reset === 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        check(8'(n), 8'(SRCC_BRK_CYC));
        rd_chk(SRCC_CTRL_OFS, 8'h04);
        rd_chk(SRCC_BLK_OFS, 8'ha5);
        check({7'h0, irq}, 8'h01);
        rd_chk(SRCC_IRQS_OFS, 8'h04);
        cyc(2);
        check({7'h0, irq}, 8'h00);
        wr_reg(SRCC_BLK_OFS, 8'h00);
        // Stop gate refused, then accepted
        wr_reg(SRCC_CTRL_OFS, 8'h00);
        cpu.pend(1'b1);
        wr_reg(SRCC_GATE_OFS, SRCC_KEY1);
        wr_reg(SRCC_GATE_OFS, SRCC_KEY2);
        rd_chk(SRCC_GATE_OFS, 8'h00);
        rd_chk(SRCC_IRQS_OFS, 8'h08);
        wr_reg(SRCC_CTRL_OFS, 8'h04);
        wr_reg(SRCC_GATE_OFS, SRCC_KEY1);
        wr_reg(SRCC_GATE_OFS, SRCC_KEY2);
        rd_chk(SRCC_GATE_OFS, 8'h01);
        cpu.pend(1'b0);
        wr_reg(SRCC_CTRL_OFS, 8'h06);
        cpu.nop2();
        cyc(1);
        check({7'h0, pll_run}, 8'h00);
        rd_chk(SRCC_STAT_OFS, 8'h02);
        seen_clk(v);
        check(v, 8'h00);
        cpu.pend(1'b1);
        cyc(3);
        rd_chk(SRCC_STAT_OFS, 8'h00);
        check({7'h0, pll_run}, 8'h01);
        rd_chk(SRCC_IRQS_OFS, 8'h02);
        cpu.pend(1'b0);
        // Stop without gate is refused
        wr_reg(SRCC_CTRL_OFS, 8'h02);
        cpu.nop2();
        rd_chk(SRCC_STAT_OFS, 8'h00);
        rd_chk(SRCC_IRQS_OFS, 8'h08);
        // Halt stops only the CPU clock
        wr_reg(SRCC_CTRL_OFS, 8'h01);
        cpu.nop2();
        rd_chk(SRCC_STAT_OFS, 8'h01);
        gap(n);
        check(8'(n), 8'd64);
        seen_clk(v);
        check(v, 8'hff);
        cpu.pend(1'b1);
        cyc(3);
        gap(n);
        check(8'(n), 8'(SRCC_SYS_DIV));
        cpu.pend(1'b0);
        // Low tick seen before the slow clock is chosen
        cpu.tick();
        rd_chk(SRCC_STAT_OFS, 8'h08);
        rd_chk(SRCC_IRQS_OFS, 8'h03);
        wr_reg(SRCC_CTRL_OFS, 8'h08);
        // Slow clock chosen: no CPU pulse without a low tick
        gap(n);
        check(8'(n), 8'd64);
        // Pin reset leaves no trace
        @(posedge ref_clk);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_pin_n <= 1'b1;
        cyc(6);
        rd_chk(SRCC_IRQS_OFS, 8'h00);
        rd_chk(SRCC_STAT_OFS, 8'h00);
        rd_chk(SRCC_CTRL_OFS, SRCC_CTRL_RST);
        report_and_stop();
    end
endmodule // tb_standby_reset_clock_control
